// *** rtl/charge_time_pkg.sv ***
// Constants shared by the charge time unit design files
package charge_time_pkg;
    localparam int unsigned ADDR_W = 2;
    localparam int unsigned DATA_W = 16;
    localparam logic [1:0] EDGE_CONTROL_ADDR = 2'h0;
    localparam logic [1:0] CURRENT_CONTROL_ADDR = 2'h1;
    localparam logic [15:0] EDGE_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] CURRENT_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] EDGE_CONTROL_WMASK = 16'hBFFF;
    localparam logic [15:0] CURRENT_CONTROL_WMASK = 16'hFF00;
    localparam int unsigned UNIT_ENABLE_BIT = 15;
    localparam int unsigned IDLE_STOP_BIT = 13;
    localparam int unsigned DELAY_GEN_BIT = 12;
    localparam int unsigned EDGE_ACCEPT_BIT = 11;
    localparam int unsigned EDGE_ORDER_BIT = 10;
    localparam int unsigned DISCHARGE_BIT = 9;
    localparam int unsigned CONV_TRIG_BIT = 8;
    localparam int unsigned SECOND_POL_BIT = 7;
    localparam int unsigned SECOND_SRC_LSB = 5;
    localparam int unsigned FIRST_POL_BIT = 4;
    localparam int unsigned FIRST_SRC_LSB = 2;
    localparam int unsigned SECOND_SEEN_BIT = 1;
    localparam int unsigned FIRST_SEEN_BIT = 0;
    localparam int unsigned TRIM_LSB = 10;
    localparam int unsigned RANGE_LSB = 8;
    localparam logic [1:0] SRC_TIMER_ONE = 2'h0;
    localparam logic [1:0] SRC_COMPARE_ONE = 2'h1;
    localparam logic [1:0] SRC_PIN_TWO = 2'h2;
    localparam logic [1:0] SRC_PIN_ONE = 2'h3;
    typedef enum logic [1:0] {ST_IDLE, ST_CHARGE, ST_PULSE} unit_state_t;
endpackage

// *** rtl/edge_event_if.sv ***
// Qualified edge events from one edge channel
`timescale 1ns/1ps
interface edge_event_if;
    logic [1:0] source;
    logic polarity;
    logic event_pulse;
    modport detector (input source, input polarity, output event_pulse);
    modport consumer (output source, output polarity, input event_pulse);
endinterface

// *** rtl/edge_detect.sv ***
// Source select and polarity qualified edge detector for one channel
`timescale 1ns/1ps
module edge_detect (
    // Clock, enable and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // Synchronised candidate sources
    input wire logic [3:0] i_sources,
    // Channel
    edge_event_if.detector ch
);
    import charge_time_pkg::*;
    logic sel_level;
    logic prev_reg;
    logic rise;
    logic fall;
    assign sel_level = i_sources[ch.source];
    assign rise = sel_level & ~prev_reg;
    assign fall = ~sel_level & prev_reg;
    // Polarity picks which transition counts
    assign ch.event_pulse = ch.polarity ? rise : fall;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_reg <= 1'b0;
        end else if (i_ce) begin
            prev_reg <= sel_level;
        end
    end
endmodule // edge_detect

// *** rtl/charge_time_unit.sv ***
// Charge time unit: edge qualification, current gating and delayed pulse
`timescale 1ns/1ps
// How it works
// - Delay mode steers current to comparator two
// - Delay mode charges from qualified edge
// - Comparator trip gives delayed pulse
// - Pulse spans first to second edge
// - Each channel picks one of four sources
// - Source codes: timer, compare, pin2, pin1
// - Polarity set means rising edges count
// - Second edge sets writable status bit
// - First edge sets bit zero status
// - Current register holds trim and range
module charge_time_unit (
    // Clock, enable and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // Register port
    input wire logic [charge_time_pkg::ADDR_W-1:0] i_addr,
    input wire logic [charge_time_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [charge_time_pkg::DATA_W-1:0] o_rdata,
    // Edge sources, comparator two trip and idle
    input wire logic i_timer_one,
    input wire logic i_output_compare_one,
    input wire logic i_edge_pin_one,
    input wire logic i_edge_pin_two,
    input wire logic i_comp_two_trip,
    input wire logic i_idle,
    // Analog controls and pulse outputs
    output logic o_current_on,
    output logic o_current_discharge,
    output logic o_route_comp_two_input_b,
    output logic [5:0] o_current_trim,
    output logic [1:0] o_current_range,
    output logic o_measure_pulse,
    output logic o_delayed_pulse_out,
    output logic o_converter_trigger
);
    import charge_time_pkg::*;

    logic rst_meta_reg;
    logic rst_sync_reg;
    logic [3:0] src_meta_reg;
    logic [3:0] src_sync_reg;
    logic trip_meta_reg;
    logic trip_sync_reg;
    logic trip_prev_reg;
    logic [15:0] edge_control_reg;
    logic [15:0] current_control_reg;
    logic [15:0] edge_control_next;
    unit_state_t state_reg;
    unit_state_t state_next;
    logic current_on_reg;
    logic discharge_reg;
    logic route_reg;
    logic measure_reg;
    logic pulse_reg;
    logic conv_reg;
    logic [15:0] rdata_reg;

    edge_event_if first_ch ();
    edge_event_if second_ch ();

    // Reset release through two flops
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Pins arrive asynchronously
    always_ff @(posedge i_core_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            src_meta_reg <= 4'h0;
            src_sync_reg <= 4'h0;
            trip_meta_reg <= 1'b0;
            trip_sync_reg <= 1'b0;
        end else if (i_ce) begin
            src_meta_reg <= {i_edge_pin_one, i_edge_pin_two, i_output_compare_one, i_timer_one};
            src_sync_reg <= src_meta_reg;
            trip_meta_reg <= i_comp_two_trip;
            trip_sync_reg <= trip_meta_reg;
        end
    end

    // Control fields
    wire unit_en = edge_control_reg[UNIT_ENABLE_BIT];
    wire run = unit_en & ~(edge_control_reg[IDLE_STOP_BIT] & i_idle);
    wire delay_mode = edge_control_reg[DELAY_GEN_BIT];
    wire accept_en = edge_control_reg[EDGE_ACCEPT_BIT];
    wire order_en = edge_control_reg[EDGE_ORDER_BIT];
    wire first_seen = edge_control_reg[FIRST_SEEN_BIT];
    wire second_seen = edge_control_reg[SECOND_SEEN_BIT];

    assign first_ch.source = edge_control_reg[FIRST_SRC_LSB +: 2];
    assign first_ch.polarity = edge_control_reg[FIRST_POL_BIT];
    assign second_ch.source = edge_control_reg[SECOND_SRC_LSB +: 2];
    assign second_ch.polarity = edge_control_reg[SECOND_POL_BIT];

    // Sources ordered so the select code indexes them directly
    edge_detect u_first (
        .i_clk(i_core_clk),
        .i_rst_n(rst_sync_reg),
        .i_ce(i_ce),
        .i_sources(src_sync_reg),
        .ch(first_ch)
    );
    edge_detect u_second (
        .i_clk(i_core_clk),
        .i_rst_n(rst_sync_reg),
        .i_ce(i_ce),
        .i_sources(src_sync_reg),
        .ch(second_ch)
    );

    wire first_ev = run & accept_en & first_ch.event_pulse;
    wire second_ev = run & accept_en & second_ch.event_pulse & (~order_en | first_seen);
    wire trip_rise = trip_sync_reg & ~trip_prev_reg;

    // Register decode
    wire wr_edge = i_wr & (i_addr == EDGE_CONTROL_ADDR);
    wire wr_curr = i_wr & (i_addr == CURRENT_CONTROL_ADDR);
    wire [15:0] edge_written = (edge_control_reg & ~EDGE_CONTROL_WMASK) | (i_wdata & EDGE_CONTROL_WMASK);
    wire [15:0] edge_base = wr_edge ? edge_written : edge_control_reg;
    // Hardware set wins over a software clear in the same cycle
    assign edge_control_next = edge_base
        | ({15'h0000, first_ev} << FIRST_SEEN_BIT)
        | ({15'h0000, second_ev} << SECOND_SEEN_BIT);
    wire [15:0] rd_mux = (i_addr == EDGE_CONTROL_ADDR) ? edge_control_reg :
                         (i_addr == CURRENT_CONTROL_ADDR) ? current_control_reg : 16'h0000;

    always_ff @(posedge i_core_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            edge_control_reg <= EDGE_CONTROL_RESET;
            current_control_reg <= CURRENT_CONTROL_RESET;
            rdata_reg <= 16'h0000;
        end else if (i_ce) begin
            edge_control_reg <= edge_control_next;
            if (wr_curr) begin
                current_control_reg <= i_wdata & CURRENT_CONTROL_WMASK;
            end
            rdata_reg <= i_rd ? rd_mux : 16'h0000;
        end
    end

    // Sequence: measure runs first edge to second; delay runs edge to trip
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (first_ev) begin
                    state_next = ST_CHARGE;
                end
            end
            ST_CHARGE: begin
                if (delay_mode ? trip_rise : second_ev) begin
                    state_next = delay_mode ? ST_PULSE : ST_IDLE;
                end
            end
            ST_PULSE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (!run) begin
            state_next = ST_IDLE;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            state_reg <= ST_IDLE;
            trip_prev_reg <= 1'b0;
            current_on_reg <= 1'b0;
            discharge_reg <= 1'b0;
            route_reg <= 1'b0;
            measure_reg <= 1'b0;
            pulse_reg <= 1'b0;
            conv_reg <= 1'b0;
        end else if (i_ce) begin
            state_reg <= state_next;
            trip_prev_reg <= trip_sync_reg;
            current_on_reg <= (state_next == ST_CHARGE) & ~edge_control_reg[DISCHARGE_BIT];
            discharge_reg <= edge_control_reg[DISCHARGE_BIT];
            route_reg <= unit_en & delay_mode;
            measure_reg <= (state_next == ST_CHARGE) & ~delay_mode;
            pulse_reg <= (state_next == ST_PULSE);
            // Converter start only after the pulse is over
            conv_reg <= edge_control_reg[CONV_TRIG_BIT] & measure_reg & (state_next != ST_CHARGE);
        end
    end

    assign o_rdata = rdata_reg;
    assign o_current_on = current_on_reg;
    assign o_current_discharge = discharge_reg;
    assign o_route_comp_two_input_b = route_reg;
    assign o_current_trim = current_control_reg[TRIM_LSB +: 6];
    assign o_current_range = current_control_reg[RANGE_LSB +: 2];
    assign o_measure_pulse = measure_reg;
    assign o_delayed_pulse_out = pulse_reg;
    assign o_converter_trigger = conv_reg;

    // Checks run on the synchronised reset so the release edges stay quiet
    a_disable_quiet: assert property (@(posedge i_core_clk) disable iff (!rst_sync_reg)
        i_ce && !run |=> !o_current_on) else $error("current on while unit off");
    a_route_follow: assert property (@(posedge i_core_clk) disable iff (!rst_sync_reg)
        i_ce && unit_en && delay_mode |=> o_route_comp_two_input_b) else $error("route missing");
    a_route_off: assert property (@(posedge i_core_clk) disable iff (!rst_sync_reg)
        i_ce && !delay_mode |=> !o_route_comp_two_input_b) else $error("route outside delay mode");
    a_charge_start: assert property (@(posedge i_core_clk) disable iff (!rst_sync_reg)
        i_ce && state_reg == ST_IDLE && first_ev && !edge_control_reg[DISCHARGE_BIT] |=> o_current_on)
        else $error("charge not started");
    a_trip_pulse: assert property (@(posedge i_core_clk) disable iff (!rst_sync_reg)
        i_ce && run && delay_mode && state_reg == ST_CHARGE && trip_rise |=> o_delayed_pulse_out)
        else $error("no delayed pulse");
    a_pulse_single: assert property (@(posedge i_core_clk) disable iff (!rst_sync_reg)
        i_ce && o_delayed_pulse_out |=> !o_delayed_pulse_out) else $error("delayed pulse too long");
    a_pulse_end: assert property (@(posedge i_core_clk) disable iff (!rst_sync_reg)
        i_ce && run && !delay_mode && state_reg == ST_CHARGE && second_ev |=> !o_measure_pulse)
        else $error("pulse did not end");
    a_first_seen: assert property (@(posedge i_core_clk) disable iff (!rst_sync_reg)
        i_ce && first_ev |=> edge_control_reg[FIRST_SEEN_BIT]) else $error("first status lost");
    a_second_seen: assert property (@(posedge i_core_clk) disable iff (!rst_sync_reg)
        i_ce && second_ev |=> edge_control_reg[SECOND_SEEN_BIT]) else $error("second status lost");
    a_edges_gated: assert property (@(posedge i_core_clk) disable iff (!rst_sync_reg)
        i_ce && !accept_en && !wr_edge |=>
        edge_control_reg[SECOND_SEEN_BIT:FIRST_SEEN_BIT] == $past(edge_control_reg[SECOND_SEEN_BIT:FIRST_SEEN_BIT]))
        else $error("edge accepted while off");
    a_order_hold: assert property (@(posedge i_core_clk) disable iff (!rst_sync_reg)
        i_ce && order_en && !first_seen && !second_seen && !wr_edge |=> !edge_control_reg[SECOND_SEEN_BIT])
        else $error("second before first");
    a_discharge_off: assert property (@(posedge i_core_clk) disable iff (!rst_sync_reg)
        i_ce && edge_control_reg[DISCHARGE_BIT] |=> o_current_discharge && !o_current_on)
        else $error("discharge ignored");
    a_trim_reg: assert property (@(posedge i_core_clk) disable iff (!rst_sync_reg)
        i_ce && wr_curr |=> o_current_trim == $past(i_wdata[TRIM_LSB +: 6])) else $error("trim not held");
    a_range_reg: assert property (@(posedge i_core_clk) disable iff (!rst_sync_reg)
        i_ce && wr_curr |=> o_current_range == $past(i_wdata[RANGE_LSB +: 2])) else $error("range not held");
    a_convert_after: assert property (@(posedge i_core_clk) disable iff (!rst_sync_reg)
        o_converter_trigger |-> !o_measure_pulse) else $error("converter start inside pulse");

    c_measure: cover property (@(posedge i_core_clk) disable iff (!rst_sync_reg)
        $fell(o_measure_pulse));
    c_order_block: cover property (@(posedge i_core_clk) disable iff (!rst_sync_reg)
        order_en && !first_seen && second_ch.event_pulse && accept_en && run);
    c_delay: cover property (@(posedge i_core_clk) disable iff (!rst_sync_reg)
        o_delayed_pulse_out);
    c_convert: cover property (@(posedge i_core_clk) disable iff (!rst_sync_reg)
        o_converter_trigger);
endmodule // charge_time_unit

// *** tb/charge_side_model.sv ***
// Far side model: edge sources and comparator two on a delay capacitor
`timescale 1ns/1ps
module charge_side_model #(
    parameter int CHARGE_CYCLES = 20
) (
    // Clock
    input wire logic i_clk,
    // Bench levels, indexed by source code
    input wire logic [3:0] i_levels,
    // Current source from the unit
    input wire logic i_current_on,
    input wire logic i_discharge,
    input wire logic i_route,
    // Sources and comparator
    output logic o_timer_one,
    output logic o_output_compare_one,
    output logic o_edge_pin_one,
    output logic o_edge_pin_two,
    output logic o_comp_two_trip
);
    int charge = 0;
    assign o_timer_one = i_levels[0];
    assign o_output_compare_one = i_levels[1];
    // Pins reach the unit only once remapped
    assign o_edge_pin_two = i_levels[2];
    assign o_edge_pin_one = i_levels[3];
    // Ramp holds when current stops, so a late trip stays visible
    // Capacitor only charges while the current is steered to comparator two
    always @(posedge i_clk) begin
        if (i_discharge)
            charge <= 0;
        else if (i_current_on && i_route && charge < CHARGE_CYCLES)
            charge <= charge + 1;
    end
    assign o_comp_two_trip = (charge >= CHARGE_CYCLES);
endmodule // charge_side_model

// *** tb/test_charge_time_unit.sv ***
// Self-checking bench for the charge time unit
`timescale 1ns/1ps
module test_charge_time_unit;
    import charge_time_pkg::*;
    typedef struct packed {logic [15:0] ctrl; logic [15:0] rd;} row_t;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic [3:0] lv = 4'h0;
    logic tmr, oc, p1, p2, trip, on, dis, route, meas, dly, conv;
    logic [5:0] trim;
    logic [1:0] rng;
    logic [3:0] v;
    int failures = 0;
    int samples_checked = 0;
    int dly_seen = 0;
    int conv_seen = 0;
    row_t rows [4] = '{'{16'h88B0, 16'h88B3}, '{16'h8844, 16'h8847},
                      '{16'h88F8, 16'h88FB}, '{16'h880C, 16'h880F}};
    charge_time_unit charge_time_unit_i (.i_core_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_timer_one(tmr),
        .i_output_compare_one(oc), .i_edge_pin_one(p1), .i_edge_pin_two(p2), .i_comp_two_trip(trip),
        .i_idle(1'b0), .o_current_on(on), .o_current_discharge(dis), .o_route_comp_two_input_b(route),
        .o_current_trim(trim), .o_current_range(rng), .o_measure_pulse(meas),
        .o_delayed_pulse_out(dly), .o_converter_trigger(conv));
    charge_side_model charge_side_model_i (.i_clk(clk), .i_levels(lv), .i_current_on(on),
        .i_discharge(dis), .i_route(route), .o_timer_one(tmr), .o_output_compare_one(oc), .o_edge_pin_one(p1),
        .o_edge_pin_two(p2), .o_comp_two_trip(trip));
    initial begin
        forever #4 clk = ~clk;
    end
    // One-cycle pulses are counted, never sampled late
    always @(posedge clk) begin
        if (dly === 1'b1)
            dly_seen++;
        if (conv === 1'b1)
            conv_seen++;
    end
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [1:0] a, input logic [15:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk16(rdata, e);
    endtask
    // Long enough for sync, detect and status update
    task automatic set_lv(input logic [3:0] x);
        @(posedge clk);
        lv <= x;
        wait_cyc(8);
    endtask
    task automatic start(input logic [15:0] c, input logic [3:0] x);
        wr_reg(EDGE_CONTROL_ADDR, 16'h0000);
        set_lv(x);
        wr_reg(EDGE_CONTROL_ADDR, c);
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(EDGE_CONTROL_ADDR, EDGE_CONTROL_RESET);
        rd_reg(CURRENT_CONTROL_ADDR, CURRENT_CONTROL_RESET);
        $display("test reset done");
        foreach (rows[i]) begin
            v = {4{rows[i].ctrl[4]}};
            start(rows[i].ctrl, v);
            v[rows[i].ctrl[3:2]] = ~rows[i].ctrl[4];
            set_lv(v);
            chk1(meas, 1'b0);
            v[rows[i].ctrl[3:2]] = rows[i].ctrl[4];
            set_lv(v);
            chk1(meas, 1'b1);
            chk1(on, 1'b1);
            v[rows[i].ctrl[6:5]] = ~rows[i].ctrl[7];
            set_lv(v);
            v[rows[i].ctrl[6:5]] = rows[i].ctrl[7];
            set_lv(v);
            chk1(meas, 1'b0);
            rd_reg(EDGE_CONTROL_ADDR, rows[i].rd);
            $display("test edge row %0d done", i);
        end
        wr_reg(CURRENT_CONTROL_ADDR, 16'hFFFF);
        rd_reg(CURRENT_CONTROL_ADDR, 16'hFF00);
        wr_reg(CURRENT_CONTROL_ADDR, 16'hA600);
        wait_cyc(1);
        chk16({8'h00, trim, rng}, 16'h00A6);
        wr_reg(EDGE_CONTROL_ADDR, 16'h4000);
        rd_reg(EDGE_CONTROL_ADDR, 16'h0000);
        rd_reg(2'h2, 16'h0000);
        $display("test register access done");
        start(16'h80B0, 4'h0);
        set_lv(4'h3);
        chk1(meas, 1'b0);
        rd_reg(EDGE_CONTROL_ADDR, 16'h80B0);
        start(16'h08B0, 4'h0);
        set_lv(4'h3);
        chk1(on, 1'b0);
        rd_reg(EDGE_CONTROL_ADDR, 16'h08B0);
        $display("test gating done");
        chk16(16'(conv_seen), 16'h0000);
        start(16'h8DB0, 4'h0);
        set_lv(4'h2);
        rd_reg(EDGE_CONTROL_ADDR, 16'h8DB0);
        set_lv(4'h3);
        chk1(meas, 1'b1);
        set_lv(4'h1);
        set_lv(4'h3);
        chk1(meas, 1'b0);
        chk16(16'(conv_seen), 16'h0001);
        rd_reg(EDGE_CONTROL_ADDR, 16'h8DB3);
        $display("test ordering done");
        start(16'h98B0, 4'h0);
        wait_cyc(1);
        chk1(route, 1'b1);
        set_lv(4'h1);
        chk1(on, 1'b1);
        chk16(16'(dly_seen), 16'h0000);
        wait_cyc(40);
        chk16(16'(dly_seen), 16'h0001);
        chk1(on, 1'b0);
        $display("test delay generation done");
        wr_reg(EDGE_CONTROL_ADDR, 16'h8200);
        wait_cyc(2);
        chk1(dis, 1'b1);
        $display("test discharge done");
        // A write while the clock enable is low must leave the register alone
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(CURRENT_CONTROL_ADDR, 16'h0400);
        ce <= 1'b1;
        rd_reg(CURRENT_CONTROL_ADDR, 16'hA600);
        $display("test clock enable done");
        @(posedge clk);
        nrst <= 1'b0;
        wait_cyc(2);
        chk1(dis, 1'b0);
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        wait_cyc(3);
        rd_reg(EDGE_CONTROL_ADDR, EDGE_CONTROL_RESET);
        rd_reg(CURRENT_CONTROL_ADDR, CURRENT_CONTROL_RESET);
        $display("test mid-run reset done");
        summarize();
    end
endmodule // test_charge_time_unit
